// ==== hdl/srus_pkg.sv ====
// constants for the scaler register upload scheduler
package srus_pkg;
  // ==========================================================
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_REGS = 11;
  localparam int IDX_W = 4;
  localparam logic [7:0] REG_BASE = 8'h50;
  localparam logic [7:0] OFS_STATIC = 8'h50;
  localparam logic [7:0] OFS_STREAM = 8'h54;
  localparam logic [7:0] OFS_RATIO = 8'h58;
  localparam logic [7:0] OFS_SCALER_CTRL = 8'h5C;
  localparam logic [7:0] OFS_VSCALE = 8'h60;
  localparam logic [7:0] OFS_VSCALE_GAIN = 8'h64;
  localparam logic [7:0] OFS_HPRESCALE = 8'h68;
  localparam logic [7:0] OFS_HFINE = 8'h6C;
  localparam logic [7:0] OFS_PICTURE = 8'h70;
  localparam logic [7:0] OFS_CHROMA_KEY = 8'h74;
  localparam logic [7:0] OFS_OUT_FORMAT = 8'h78;
  localparam logic [7:0] OFS_STATUS = 8'h7C;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  // ==========================================================
  // upload groups
  localparam int NUM_GROUPS = 5;
  localparam logic [2:0] GRP_PORT1 = 3'h0;
  localparam logic [2:0] GRP_PORT2 = 3'h1;
  localparam logic [2:0] GRP_RATIO = 3'h2;
  localparam logic [2:0] GRP_WINDOW = 3'h3;
  localparam logic [2:0] GRP_LINE = 3'h4;
  localparam logic [2:0] GRP_NONE = 3'h7;
  localparam logic [IDX_W-1:0] IDX_STATIC = 4'h0;
  localparam logic [IDX_W-1:0] IDX_STREAM = 4'h1;
  localparam logic [2:0] REG_GROUP [0:NUM_REGS-1] = '{
    GRP_NONE, GRP_PORT1, GRP_RATIO, GRP_WINDOW, GRP_WINDOW,
    GRP_WINDOW, GRP_LINE, GRP_LINE, GRP_LINE, GRP_WINDOW, GRP_WINDOW};
  // ==========================================================
  // field positions
  localparam int STATIC_PORT1_EDGE_BIT = 0;
  localparam int STATIC_PORT2_EDGE_BIT = 1;
  localparam int STATIC_RATIO_WRITE_BIT = 2;
  localparam int STREAM_HALF_W = 16;
  localparam int STATUS_PEND_LSB = 0;
  localparam int STATUS_IDLE_LSB = 8;
endpackage

// ==== hdl/srus_top.sv ====
// scaler register upload scheduler: shadow and active register bank
`timescale 1ns/100ps
module srus_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [31:0] reg_rd_data,
  // video port sync pins
  input wire logic port_one_vsync_pin,
  input wire logic port_two_vsync_pin,
  // ratio scaler path
  input wire logic rs_out_vertical_gate,
  input wire logic rs_field_start,
  // main scaler path
  input wire logic main_out_vertical_gate,
  input wire logic main_acq_vertical_pulse,
  input wire logic main_out_horizontal_gate,
  input wire logic main_acq_horizontal_gate,
  // video events toward the command sequencer
  output logic port_one_blanking_pulse,
  output logic port_two_blanking_pulse,
  output logic ratio_scaler_field_done,
  output logic scaler_window_done,
  output logic scaler_line_done,
  // active register values toward the data paths
  output logic [31:0] interface_static_settings,
  output logic [31:0] port_stream_handling,
  output logic [31:0] ratio_scaler_control,
  output logic [31:0] scaler_control,
  output logic [31:0] vertical_scale,
  output logic [31:0] vertical_scale_gain,
  output logic [31:0] horizontal_prescale,
  output logic [31:0] horizontal_fine_scale,
  output logic [31:0] picture_adjust_control,
  output logic [31:0] chroma_key_range,
  output logic [31:0] output_format_clip_control
);
  localparam int NG = srus_pkg::NUM_GROUPS;
  localparam int NR = srus_pkg::NUM_REGS;
  localparam int HW = srus_pkg::STREAM_HALF_W;

  logic [31:0] shadow_reg [0:NR-1];
  logic [31:0] active_reg [0:NR-1];
  logic [NG-1:0] pending_reg;
  logic [NG-1:0] upload;
  logic [NG-1:0] wr_hit;
  logic [NG-1:0] event_fire;
  logic [7:0] fire_ext;
  logic [7:0] rel_addr;
  logic [3:0] reg_idx;
  logic in_map;
  logic status_hit;
  logic [31:0] rd_data_reg;
  logic [31:0] status_word;
  logic p1_level_reg;
  logic p2_level_reg;
  logic p1_level;
  logic p2_level;
  logic rs_gate_reg;
  logic win_gate_reg;
  logic line_gate_reg;
  logic line_acq_reg;
  logic rs_fall;
  logic win_fall;
  logic line_fall;
  logic line_acq_rise;
  logic rs_idle_reg;
  logic win_idle_reg;
  logic line_idle_reg;
  logic rs_write_mode;
  logic [NG-1:0] event_out_reg;

  // ==========================================================
  // address decode
  assign rel_addr = reg_addr - srus_pkg::REG_BASE;
  assign reg_idx = rel_addr[5:2];
  assign in_map = (reg_addr >= srus_pkg::OFS_STATIC)
    && (reg_addr <= srus_pkg::OFS_OUT_FORMAT)
    && (reg_addr[1:0] == srus_pkg::WORD_ALIGN);
  assign status_hit = (reg_addr == srus_pkg::OFS_STATUS);

  // ==========================================================
  // shadow registers written by software
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NR; i++) begin
        shadow_reg[i] <= srus_pkg::RESET_VALUE;
      end
    end else if (reg_wr_en && in_map) begin
      shadow_reg[reg_idx] <= reg_wr_data;
    end
  end

  always_comb begin
    wr_hit = '0;
    if (reg_wr_en && in_map) begin
      if (reg_idx == srus_pkg::IDX_STREAM) begin
        wr_hit[srus_pkg::GRP_PORT1] = 1'b1;
        wr_hit[srus_pkg::GRP_PORT2] = 1'b1;
      end else if (srus_pkg::REG_GROUP[reg_idx] != srus_pkg::GRP_NONE) begin
        wr_hit[srus_pkg::REG_GROUP[reg_idx]] = 1'b1;
      end
    end
  end

  // ==========================================================
  // read port
  // idle flags from bit 8 upward, pending flags at the bottom
  assign status_word = {16'h0000, 5'h00, rs_idle_reg, win_idle_reg,
    line_idle_reg, 3'h0, pending_reg};

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data_reg <= srus_pkg::RESET_VALUE;
    end else if (reg_rd_en && in_map) begin
      rd_data_reg <= shadow_reg[reg_idx];
    end else if (reg_rd_en && status_hit) begin
      rd_data_reg <= status_word;
    end else begin
      rd_data_reg <= srus_pkg::RESET_VALUE;
    end
  end
  assign reg_rd_data = rd_data_reg;

  // ==========================================================
  // input history for edge detection
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      p1_level_reg <= 1'b0;
      p2_level_reg <= 1'b0;
      rs_gate_reg <= 1'b0;
      win_gate_reg <= 1'b0;
      line_gate_reg <= 1'b0;
      line_acq_reg <= 1'b1;
    end else begin
      p1_level_reg <= p1_level;
      p2_level_reg <= p2_level;
      rs_gate_reg <= rs_out_vertical_gate;
      win_gate_reg <= main_out_vertical_gate;
      line_gate_reg <= main_out_horizontal_gate;
      line_acq_reg <= main_acq_horizontal_gate;
    end
  end

  // edge select flips the pin, so changing it can look like an edge
  assign p1_level = port_one_vsync_pin
    ^ active_reg[0][srus_pkg::STATIC_PORT1_EDGE_BIT];
  assign p2_level = port_two_vsync_pin
    ^ active_reg[0][srus_pkg::STATIC_PORT2_EDGE_BIT];
  assign rs_fall = rs_gate_reg && !rs_out_vertical_gate;
  assign win_fall = win_gate_reg && !main_out_vertical_gate;
  assign line_fall = line_gate_reg && !main_out_horizontal_gate;
  assign line_acq_rise = !line_acq_reg && main_acq_horizontal_gate;
  assign rs_write_mode = active_reg[0][srus_pkg::STATIC_RATIO_WRITE_BIT];

  // ==========================================================
  // video events
  always_comb begin
    event_fire = '0;
    event_fire[srus_pkg::GRP_PORT1] = p1_level && !p1_level_reg;
    event_fire[srus_pkg::GRP_PORT2] = p2_level && !p2_level_reg;
    event_fire[srus_pkg::GRP_RATIO] = rs_fall && rs_write_mode;
    event_fire[srus_pkg::GRP_WINDOW] = win_fall;
    event_fire[srus_pkg::GRP_LINE] = line_fall;
  end

  // ==========================================================
  // idle intervals
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rs_idle_reg <= 1'b0;
      win_idle_reg <= 1'b0;
      line_idle_reg <= 1'b0;
    end else begin
      if (rs_fall) begin
        rs_idle_reg <= 1'b1;
      end else if (rs_field_start) begin
        rs_idle_reg <= 1'b0;
      end
      if (win_fall) begin
        win_idle_reg <= 1'b1;
      end else if (main_acq_vertical_pulse) begin
        win_idle_reg <= 1'b0;
      end
      if (line_fall) begin
        line_idle_reg <= 1'b1;
      end else if (line_acq_rise) begin
        line_idle_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pending uploads: one per event, set beats clear
  assign upload = event_fire & pending_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= (pending_reg & ~upload) | wr_hit;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      event_out_reg <= '0;
    end else begin
      event_out_reg <= event_fire;
    end
  end
  assign port_one_blanking_pulse = event_out_reg[srus_pkg::GRP_PORT1];
  assign port_two_blanking_pulse = event_out_reg[srus_pkg::GRP_PORT2];
  assign ratio_scaler_field_done = event_out_reg[srus_pkg::GRP_RATIO];
  assign scaler_window_done = event_out_reg[srus_pkg::GRP_WINDOW];
  assign scaler_line_done = event_out_reg[srus_pkg::GRP_LINE];

  // ==========================================================
  // active registers, one copy per entry
  assign fire_ext = {3'h7, upload};

  genvar gi;
  generate
    for (gi = 0; gi < NR; gi++) begin : g_active
      if (gi == srus_pkg::IDX_STREAM) begin : g_split
        always_ff @(posedge ref_clk or posedge reset) begin
          if (reset) begin
            active_reg[gi] <= srus_pkg::RESET_VALUE;
          end else begin
            if (upload[srus_pkg::GRP_PORT1]) begin
              active_reg[gi][HW-1:0] <= shadow_reg[gi][HW-1:0];
            end
            if (upload[srus_pkg::GRP_PORT2]) begin
              active_reg[gi][31:HW] <= shadow_reg[gi][31:HW];
            end
          end
        end
      end else begin : g_whole
        always_ff @(posedge ref_clk or posedge reset) begin
          if (reset) begin
            active_reg[gi] <= srus_pkg::RESET_VALUE;
          end else if (fire_ext[srus_pkg::REG_GROUP[gi]]) begin
            active_reg[gi] <= shadow_reg[gi];
          end
        end
      end
    end
  endgenerate

  assign interface_static_settings = active_reg[0];
  assign port_stream_handling = active_reg[1];
  assign ratio_scaler_control = active_reg[2];
  assign scaler_control = active_reg[3];
  assign vertical_scale = active_reg[4];
  assign vertical_scale_gain = active_reg[5];
  assign horizontal_prescale = active_reg[6];
  assign horizontal_fine_scale = active_reg[7];
  assign picture_adjust_control = active_reg[8];
  assign chroma_key_range = active_reg[9];
  assign output_format_clip_control = active_reg[10];

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence win_upload_s;
    win_fall && pending_reg[srus_pkg::GRP_WINDOW];
  endsequence
  sequence line_upload_s;
    line_fall && pending_reg[srus_pkg::GRP_LINE];
  endsequence

  AST_EDGE_SELECT_GLITCH: assert property (
    $changed(active_reg[0][srus_pkg::STATIC_PORT1_EDGE_BIT])
    && $stable(port_one_vsync_pin) && p1_level
    |-> event_fire[srus_pkg::GRP_PORT1])
    else $error("edge select change gave no pulse");
  AST_PORT1_UPLOAD: assert property (
    event_fire[srus_pkg::GRP_PORT1] && pending_reg[srus_pkg::GRP_PORT1]
    |=> port_stream_handling[HW-1:0] == $past(shadow_reg[1][HW-1:0])
    && port_one_blanking_pulse)
    else $error("port one half not uploaded");
  AST_PORT2_UPLOAD: assert property (
    event_fire[srus_pkg::GRP_PORT2] && pending_reg[srus_pkg::GRP_PORT2]
    |=> port_stream_handling[31:HW] == $past(shadow_reg[1][31:HW]))
    else $error("port two half not uploaded");
  AST_RATIO_WRITE_ONLY: assert property (
    $changed(ratio_scaler_control) |-> $past(rs_fall && rs_write_mode))
    else $error("ratio control changed outside write idle");
  AST_WINDOW_GROUP: assert property (
    win_upload_s |=> scaler_control == $past(shadow_reg[3])
    && output_format_clip_control == $past(shadow_reg[10])
    && scaler_window_done)
    else $error("window group not uploaded");
  AST_WINDOW_IDLE: assert property (
    win_fall ##1 (!main_acq_vertical_pulse && !win_fall)[*2]
    |-> win_idle_reg)
    else $error("window idle dropped early");
  AST_LINE_GROUP: assert property (
    line_upload_s |=> horizontal_prescale == $past(shadow_reg[6])
    && picture_adjust_control == $past(shadow_reg[8]))
    else $error("line group not uploaded");
  AST_LINE_IDLE: assert property (
    line_acq_rise && !line_fall |=> !line_idle_reg)
    else $error("line idle not ended by acquisition rise");
  AST_SINGLE_UPLOAD: assert property (
    upload[srus_pkg::GRP_LINE] && !wr_hit[srus_pkg::GRP_LINE]
    ##1 !wr_hit[srus_pkg::GRP_LINE] |=> !upload[srus_pkg::GRP_LINE])
    else $error("second upload from one event");
  AST_PENDING_CLEAR: assert property (
    upload[srus_pkg::GRP_WINDOW] && !wr_hit[srus_pkg::GRP_WINDOW]
    |=> !pending_reg[srus_pkg::GRP_WINDOW])
    else $error("pending not cleared by upload");
  AST_DONE_AFTER_UPLOAD: assert property (
    scaler_line_done |-> !pending_reg[srus_pkg::GRP_LINE]
    || $past(wr_hit[srus_pkg::GRP_LINE]))
    else $error("line done seen before upload finished");
  AST_GROUP_ATOMIC: assert property (
    $changed(horizontal_fine_scale) || $changed(picture_adjust_control)
    |-> $past(upload[srus_pkg::GRP_LINE]))
    else $error("line group changed piecemeal");
endmodule

// ==== test/srus_video_model.sv ====
// partner model: sync pins and scaler data path timing
`timescale 1ns/100ps
module srus_video_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // commands from the bench
  input wire logic ev_go,
  input wire logic ev_op,
  input wire logic [2:0] ev_grp,
  // sync pins and data path timing
  output logic port_one_vsync_pin,
  output logic port_two_vsync_pin,
  output logic rs_out_vertical_gate,
  output logic rs_field_start,
  output logic main_out_vertical_gate,
  output logic main_acq_vertical_pulse,
  output logic main_out_horizontal_gate,
  output logic main_acq_horizontal_gate
);
  // ==========================================================
  // op 0 opens an idle interval, op 1 restarts the data path
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      port_one_vsync_pin <= 1'b0;
      port_two_vsync_pin <= 1'b0;
      rs_out_vertical_gate <= 1'b1;
      rs_field_start <= 1'b0;
      main_out_vertical_gate <= 1'b1;
      main_acq_vertical_pulse <= 1'b0;
      main_out_horizontal_gate <= 1'b1;
      main_acq_horizontal_gate <= 1'b1;
    end else begin
      rs_field_start <= 1'b0;
      main_acq_vertical_pulse <= 1'b0;
      if (ev_go) begin
        case (ev_grp)
          srus_pkg::GRP_PORT1: port_one_vsync_pin <= !ev_op;
          srus_pkg::GRP_PORT2: port_two_vsync_pin <= !ev_op;
          srus_pkg::GRP_RATIO: begin
            rs_out_vertical_gate <= ev_op;
            rs_field_start <= ev_op;
          end
          srus_pkg::GRP_WINDOW: begin
            main_out_vertical_gate <= ev_op;
            main_acq_vertical_pulse <= ev_op;
          end
          default: begin
            main_out_horizontal_gate <= ev_op;
            main_acq_horizontal_gate <= ev_op;
          end
        endcase
      end
    end
  end
endmodule

// ==== test/srus_top_tb_top.sv ====
// self-checking bench for the scaler register upload scheduler
`timescale 1ns/100ps
module srus_top_tb_top;
  typedef struct {logic [2:0] g; logic [159:0] v;} srus_note_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wr_data = 32'h0000_0000;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [31:0] reg_rd_data;
  logic ev_go = 1'b0;
  logic ev_op = 1'b0;
  logic [2:0] ev_grp = 3'h0;
  logic p1_pin, p2_pin, rs_vg, rs_fs, m_vg, m_vp, m_hg, m_ahg;
  logic [4:0] pulse;
  logic [31:0] outs [0:10];
  logic [31:0] sh [0:10];
  logic [31:0] act [0:10];
  logic [4:0] pend = 5'h00;
  logic [2:0] idl = 3'h0;
  logic [31:0] seed = 32'h0001_429d;
  logic rd_seen = 1'b0;
  logic [2:0] mg;
  srus_note_t nt;
  srus_note_t notes [$];
  logic [31:0] rd_exp [$];
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // ==========================================================
  // design and partner
  srus_top i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .port_one_vsync_pin(p1_pin), .port_two_vsync_pin(p2_pin),
    .rs_out_vertical_gate(rs_vg), .rs_field_start(rs_fs),
    .main_out_vertical_gate(m_vg), .main_acq_vertical_pulse(m_vp),
    .main_out_horizontal_gate(m_hg), .main_acq_horizontal_gate(m_ahg),
    .port_one_blanking_pulse(pulse[0]), .port_two_blanking_pulse(pulse[1]),
    .ratio_scaler_field_done(pulse[2]), .scaler_window_done(pulse[3]),
    .scaler_line_done(pulse[4]), .interface_static_settings(outs[0]),
    .port_stream_handling(outs[1]), .ratio_scaler_control(outs[2]),
    .scaler_control(outs[3]), .vertical_scale(outs[4]),
    .vertical_scale_gain(outs[5]), .horizontal_prescale(outs[6]),
    .horizontal_fine_scale(outs[7]), .picture_adjust_control(outs[8]),
    .chroma_key_range(outs[9]), .output_format_clip_control(outs[10]));
  srus_video_model i_video (.ref_clk(ref_clk), .reset(reset),
    .ev_go(ev_go), .ev_op(ev_op), .ev_grp(ev_grp),
    .port_one_vsync_pin(p1_pin), .port_two_vsync_pin(p2_pin),
    .rs_out_vertical_gate(rs_vg), .rs_field_start(rs_fs),
    .main_out_vertical_gate(m_vg), .main_acq_vertical_pulse(m_vp),
    .main_out_horizontal_gate(m_hg), .main_acq_horizontal_gate(m_ahg));
  always #2 ref_clk = !ref_clk;
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [159:0] e,
      input logic [159:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [159:0] pack(input logic [2:0] g,
      input logic [31:0] r [0:10]);
    case (g)
      srus_pkg::GRP_RATIO: pack = {128'h0, r[2]};
      srus_pkg::GRP_WINDOW: pack = {r[3], r[4], r[5], r[9], r[10]};
      srus_pkg::GRP_LINE: pack = {32'h0, r[6], r[7], r[8]};
      default: pack = {128'h0, r[1]};
    endcase
  endfunction
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] stat();
    return {21'h0, idl, 3'h0, pend};
  endfunction
  task automatic drv(input logic w, r, input logic [7:0] a,
      input logic [31:0] d, input logic g, o, input logic [2:0] e);
    reg_wr_en <= w;
    reg_rd_en <= r;
    reg_addr <= a;
    reg_wr_data <= d;
    ev_go <= g;
    ev_op <= o;
    ev_grp <= e;
    @(posedge ref_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) drv(1'b0, 1'b0, 8'h00, 32'h0, 1'b0, 1'b0, 3'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    if (a >= srus_pkg::REG_BASE && a <= srus_pkg::OFS_OUT_FORMAT &&
        a[1:0] == srus_pkg::WORD_ALIGN) begin
      i = (a - srus_pkg::REG_BASE) >> 2;
      sh[i] = d;
      if (i == 0) act[0] = d;
      else pend[srus_pkg::REG_GROUP[i]] = 1'b1;
      if (i == 1) pend[srus_pkg::GRP_PORT2] = 1'b1;
    end
    drv(1'b1, 1'b0, a, d, 1'b0, 1'b0, 3'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_exp.push_back(e);
    drv(1'b0, 1'b1, a, 32'h0, 1'b0, 1'b0, 3'h0);
  endtask
  task automatic rd_all();
    for (int i = 0; i < 13; i++) begin
      rd(srus_pkg::REG_BASE + 8'(4 * i),
        i < 11 ? sh[i] : (i == 11 ? stat() : 32'h0));
    end
    rd(8'h51, 32'h0);
  endtask
  task automatic note(input logic [2:0] g);
    if (pend[g]) begin
      for (int i = 2; i < 11; i++)
        if (srus_pkg::REG_GROUP[i] == g) act[i] = sh[i];
      if (g == srus_pkg::GRP_PORT1) act[1][15:0] = sh[1][15:0];
      if (g == srus_pkg::GRP_PORT2) act[1][31:16] = sh[1][31:16];
    end
    pend[g] = 1'b0;
    notes.push_back('{g, pack(g, act)});
  endtask
  task automatic ev(input logic o, input logic [2:0] g, input logic up);
    if (up) note(g);
    if (g == srus_pkg::GRP_LINE) idl[0] = !o;
    if (g == srus_pkg::GRP_WINDOW) idl[1] = !o;
    if (g == srus_pkg::GRP_RATIO) idl[2] = !o & act[0][2];
    drv(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, o, g);
    idle(4);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // result monitor and timeout
  always @(posedge ref_clk) begin
    if (rd_seen) chk("read data", rd_exp.pop_front(), reg_rd_data);
    else if (reg_rd_data !== 32'h0) chk("idle read data", 32'h0, reg_rd_data);
    rd_seen <= reg_rd_en;
    if (|pulse) begin
      mg = pulse[0] ? srus_pkg::GRP_PORT1 : pulse[1] ? srus_pkg::GRP_PORT2 :
        pulse[2] ? srus_pkg::GRP_RATIO : pulse[3] ? srus_pkg::GRP_WINDOW :
        srus_pkg::GRP_LINE;
      if (notes.size() == 0) chk("unexpected event", 160'h0, 160'h1);
      else begin
        nt = notes.pop_front();
        chk("event group", nt.g, mg);
        chk("uploaded values", nt.v, pack(mg, outs));
      end
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      print_verdict();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < 11; i++) sh[i] = srus_pkg::RESET_VALUE;
    act = sh;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 11; i++) chk("reset output", 32'h0, outs[i]);
    rd_all();
    wr(srus_pkg::OFS_STATIC, 32'h0000_0000);
    for (int i = 1; i < 11; i++) wr(srus_pkg::REG_BASE + 8'(4 * i), xs());
    wr(8'h80, xs());
    wr(srus_pkg::OFS_STATUS, xs());
    wr(8'h55, xs());
    idle(2);
    rd_all();
    for (int i = 1; i < 11; i++) chk("held active", act[i], outs[i]);
    ev(1'b0, srus_pkg::GRP_LINE, 1'b1);
    rd(srus_pkg::OFS_STATUS, stat());
    ev(1'b1, srus_pkg::GRP_LINE, 1'b0);
    ev(1'b0, srus_pkg::GRP_LINE, 1'b1);
    wr(srus_pkg::OFS_HPRESCALE, xs());
    ev(1'b1, srus_pkg::GRP_LINE, 1'b0);
    chk("prescale held", act[6], outs[6]);
    ev(1'b0, srus_pkg::GRP_LINE, 1'b1);
    ev(1'b1, srus_pkg::GRP_LINE, 1'b0);
    ev(1'b0, srus_pkg::GRP_WINDOW, 1'b1);
    rd(srus_pkg::OFS_STATUS, stat());
    ev(1'b1, srus_pkg::GRP_WINDOW, 1'b0);
    rd(srus_pkg::OFS_STATUS, stat());
    ev(1'b0, srus_pkg::GRP_PORT1, 1'b1);
    ev(1'b1, srus_pkg::GRP_PORT1, 1'b0);
    ev(1'b0, srus_pkg::GRP_PORT2, 1'b1);
    ev(1'b1, srus_pkg::GRP_PORT2, 1'b0);
    note(srus_pkg::GRP_PORT1);
    wr(srus_pkg::OFS_STATIC, 32'h0000_0001);
    idle(4);
    chk("static copy", act[0], outs[0]);
    wr(srus_pkg::OFS_STREAM, xs());
    ev(1'b0, srus_pkg::GRP_PORT1, 1'b0);
    ev(1'b1, srus_pkg::GRP_PORT1, 1'b1);
    ev(1'b0, srus_pkg::GRP_PORT2, 1'b1);
    ev(1'b1, srus_pkg::GRP_PORT2, 1'b0);
    wr(srus_pkg::OFS_RATIO, xs());
    ev(1'b0, srus_pkg::GRP_RATIO, 1'b0);
    chk("ratio held", act[2], outs[2]);
    ev(1'b1, srus_pkg::GRP_RATIO, 1'b0);
    wr(srus_pkg::OFS_STATIC, 32'h0000_0005);
    ev(1'b0, srus_pkg::GRP_RATIO, 1'b1);
    rd(srus_pkg::OFS_STATUS, stat());
    ev(1'b1, srus_pkg::GRP_RATIO, 1'b0);
    rd_all();
    idle(4);
    chk("events left", 160'h0, 160'(notes.size()));
    print_verdict();
  end
endmodule
